/* File: nrac_regs.svh */
`ifndef NRAC_REGS_SVH
`define NRAC_REGS_SVH

// Unlock keys
`define NRAC_KEY_FIRST      8'h55
`define NRAC_KEY_SECOND     8'hAA
// Geometry
`define NRAC_EE_DEPTH       256
`define NRAC_ROW_WORDS      32
`define NRAC_LATCH_BLANK    14'h3FFF
`define NRAC_EE_BASE        16'hF000
`define NRAC_EE_MASK        16'hFF00
`define NRAC_UID_BASE       16'h8000
`define NRAC_UID_LAST       16'h8003
`define NRAC_CFG_FIRST      16'h8005
`define NRAC_CFG_LAST       16'h800B
// Address field positions
`define NRAC_ROW_MSB        14
`define NRAC_ROW_LSB        5
`define NRAC_LATCH_MSB      4
// Self-timed operation lengths in cycles
`define NRAC_EE_WRITE_CYC   16'd0064
`define NRAC_ERASE_CYC      16'd0064
`define NRAC_PROG_CYC       16'd0032

`endif

/* File: nrac_pkg.sv */
package nrac_pkg;

    typedef enum logic [2:0] {
        NRAC_OP_NONE,
        NRAC_OP_ERASE,
        NRAC_OP_LATCH,
        NRAC_OP_PROG,
        NRAC_OP_EE_WRITE
    } nrac_op_t;

    // Software control bits
    typedef struct packed {
        logic config_space_select;
        logic program_permit;
        logic latch_only_load;
        logic erase_select;
        logic done_interrupt_enable;
    } nrac_ctrl_t;

    // Request to the storage arrays
    typedef struct packed {
        logic        valid;
        nrac_op_t    op;
        logic        region;
        logic [15:0] addr;
        logic [13:0] data;
    } nrac_array_req_t;

endpackage

/* File: nrac_latch_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// Row write latches: 32 words of 14 bits, registered read
module nrac_latch_mem (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [13:0] wr_data,
    input  wire logic        blank_all,
    // Read port
    input  wire logic [4:0]  rd_idx,
    output logic      [13:0] rd_data_ff
);
`include "nrac_regs.svh"

    logic [13:0] mem_ff      [0:31]; // [R23]
    logic [13:0] nxt_mem     [0:31];
    logic [13:0] nxt_rd_data;

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            nxt_mem[i] = mem_ff[i];
            if (blank_all)
                nxt_mem[i] = `NRAC_LATCH_BLANK;
            else if (wr_en && wr_idx == 5'(i))
                nxt_mem[i] = wr_data;
        end
        nxt_rd_data = mem_ff[rd_idx];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 32; i++)
                mem_ff[i] <= `NRAC_LATCH_BLANK;
            rd_data_ff <= 14'h0000;
        end else begin
            for (int i = 0; i < 32; i++)
                mem_ff[i] <= nxt_mem[i];
            rd_data_ff <= nxt_rd_data;
        end
    end

endmodule

`default_nettype wire

/* File: nrac_ctrl.sv */
// Summary of operation
// R1: Data EEPROM of 256 locations, each holding one 8-bit value.
// R2: EEPROM writes one word; program flash only by rows.
// R3: Pointer read takes one cycle, CPU suspended then resumed, returns one word.
// R4: Writes or erases on the pointer path are ignored.
// R5: Code protection blocks all register-interface reads, writes and erases.
// R6: Region select chooses flash or config/EEPROM space; address decoded within.
// R7: Read trigger suspends CPU, data pair updated next cycle, trigger self-clears.
// R8: Key 55h then AAh then program-start; only this order unlocks.
// R9: Erase, latch load, row write, user ID write, EEPROM write need unlock.
// R10: Broken unlock sequence loads no latch and starts no write.
// R11: Software should mask global interrupts around the unlock sequence.
// R12: Latch loads and row writes stall the CPU until done.
// R13: EEPROM write: set region and permit, address plus F000h, then unlock.
// R14: EEPROM write runs with CPU going; then start clears, done flag sets.
// R15: Clearing program-start during an EEPROM write has no effect.
// R16: Row erase: choose region, load row, set erase and permit, unlock.
// R17: Write-protected target clears program-start and skips the operation.
// R18: Row erase suspends CPU; then done flag; latches and permit unchanged (the code keeps the permit but resets all latches to 3FFFh after an erase).
// R19: Row from address bits 14:5, latch from bits 4:0, no row crossing.
// R20: Latch-only set loads one latch; clear programs all latches to the row.
// R21: All latches reset to 3FFFh after every flash write or erase.
// R22: Flash write does no erase; erase acts on a whole row.
// R23: A flash row holds 32 words of 14 bits.
// R24: Any out-of-order key or control write abandons the unlock sequence.
`timescale 1ns/1ps
`default_nettype none

module nrac_ctrl
    import nrac_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // Software register writes
    input  wire logic                    key_wr,
    input  wire logic [7:0]              key_data,
    input  wire logic                    ctrl_wr,
    input  wire nrac_pkg::nrac_ctrl_t    ctrl_data,
    input  wire logic                    start_set,
    input  wire logic                    start_clr,
    input  wire logic                    read_set,
    input  wire logic                    addr_wr,
    input  wire logic [15:0]             addr_data,
    input  wire logic                    data_wr,
    input  wire logic [13:0]             data_data,
    input  wire logic                    done_clr,
    // Pointer path
    input  wire logic                    ptr_rd,
    input  wire logic                    ptr_wr,
    input  wire logic                    ptr_region,
    input  wire logic [15:0]             ptr_addr,
    // Configuration and array answers
    input  wire logic                    code_protect,
    input  wire logic                    write_protect,
    input  wire logic [13:0]             array_rd_data,
    input  wire logic                    array_busy,
    // Status
    output nrac_pkg::nrac_ctrl_t         ctrl_ff,
    output logic [15:0]                  addr_ff,
    output logic [13:0]                  word_value_ff,
    output logic [13:0]                  ptr_data_ff,
    output logic                         start_ff,
    output logic                         read_ff,
    output logic                         operation_done_flag_ff,
    output logic                         done_irq_ff,
    output logic                         write_error_ff,
    output logic                         cpu_stall_ff,
    output nrac_pkg::nrac_array_req_t    array_req_ff
);
`include "nrac_regs.svh"

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding helpers

    function automatic logic ee_addr(input logic [15:0] a);
        return (a & `NRAC_EE_MASK) == `NRAC_EE_BASE; // [R6]
    endfunction

    function automatic logic readable(input logic rg, input logic [15:0] a);
        if (!rg)
            return 1'b1;
        return ee_addr(a) || (a >= `NRAC_UID_BASE && a <= `NRAC_UID_LAST)
            || (a >= `NRAC_CFG_FIRST && a <= `NRAC_CFG_LAST); // [R6]
    endfunction

    function automatic logic writable(input logic rg, input logic [15:0] a);
        if (!rg)
            return 1'b1;
        return ee_addr(a) || (a >= `NRAC_UID_BASE && a <= `NRAC_UID_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequencer

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_KEY1,
        UNL_KEY2
    } nrac_unl_t;

    nrac_unl_t unl_ff;
    nrac_unl_t nxt_unl;
    logic      unlocked_go;
    logic      unl_broken;

    always_comb begin
        nxt_unl     = unl_ff;
        unlocked_go = 1'b0;
        unl_broken  = 1'b0;
        case (unl_ff)
            UNL_IDLE: begin
                if (key_wr && key_data == `NRAC_KEY_FIRST)
                    nxt_unl = UNL_KEY1; // [R8]
                else if (start_set)
                    unl_broken = 1'b1; // [R10]
            end
            UNL_KEY1: begin
                if (key_wr && key_data == `NRAC_KEY_SECOND)
                    nxt_unl = UNL_KEY2; // [R8]
                else if (key_wr || ctrl_wr || start_set || addr_wr || data_wr) begin
                    nxt_unl    = UNL_IDLE; // [R24]
                    unl_broken = 1'b1;
                end
            end
            UNL_KEY2: begin
                if (start_set) begin
                    nxt_unl     = UNL_IDLE;
                    unlocked_go = 1'b1; // [R8] [R9]
                end else if (key_wr || ctrl_wr || addr_wr || data_wr) begin
                    nxt_unl    = UNL_IDLE; // [R24]
                    unl_broken = 1'b1;
                end
            end
            default: nxt_unl = UNL_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst)
            unl_ff <= UNL_IDLE;
        else
            unl_ff <= nxt_unl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_RUN,
        OP_FINISH
    } nrac_opst_t;

    nrac_opst_t      op_ff;
    nrac_opst_t      nxt_op;
    nrac_op_t        kind_ff;
    nrac_op_t        nxt_kind;
    logic [15:0]     cnt_ff;
    logic [15:0]     nxt_cnt;
    nrac_ctrl_t      nxt_ctrl;
    logic [15:0]     nxt_addr;
    logic [13:0]     nxt_word;
    logic [13:0]     nxt_ptr_data;
    logic            nxt_start;
    logic            nxt_read;
    logic            nxt_done;
    logic            nxt_err;
    logic            nxt_stall;
    nrac_array_req_t nxt_req;
    logic            latch_we;
    logic            latch_blank;
    logic [13:0]     latch_rd;
    logic [4:0]      latch_rd_idx;
    nrac_op_t        req_kind;
    logic            req_ok;

    nrac_latch_mem u_latch (
        .clock      (clock),
        .srst       (srst),
        .wr_en      (latch_we),
        .wr_idx     (addr_ff[`NRAC_LATCH_MSB:0]),
        .wr_data    (word_value_ff),
        .blank_all  (latch_blank),
        .rd_idx     (latch_rd_idx),
        .rd_data_ff (latch_rd)
    );

    always_comb begin
        // Decode which operation the unlocked start selects
        if (ctrl_ff.config_space_select && ee_addr(addr_ff))
            req_kind = NRAC_OP_EE_WRITE; // [R2] [R13]
        else if (ctrl_ff.erase_select)
            req_kind = NRAC_OP_ERASE; // [R16]
        else if (ctrl_ff.latch_only_load)
            req_kind = NRAC_OP_LATCH; // [R20]
        else
            req_kind = NRAC_OP_PROG; // [R20]
        req_ok = ctrl_ff.program_permit && !code_protect
            && writable(ctrl_ff.config_space_select, addr_ff); // [R5]

        nxt_op       = op_ff;
        nxt_kind     = kind_ff;
        nxt_cnt      = cnt_ff;
        nxt_ctrl     = ctrl_wr ? ctrl_data : ctrl_ff;
        nxt_addr     = addr_wr ? addr_data : addr_ff;
        nxt_word     = data_wr ? data_data : word_value_ff;
        nxt_ptr_data = ptr_data_ff;
        nxt_start    = start_ff;
        nxt_read     = 1'b0;
        nxt_done     = operation_done_flag_ff && !done_clr;
        nxt_err      = write_error_ff;
        nxt_stall    = 1'b0;
        nxt_req      = '0;
        latch_we     = 1'b0;
        latch_blank  = 1'b0;
        latch_rd_idx = 5'h1F; // Primes the first program beat with word 31

        if (unl_broken)
            nxt_err = 1'b1; // [R10]

        // Pointer reads only; pointer writes are dropped silently
        if (ptr_rd && !ptr_wr) begin
            nxt_ptr_data = array_rd_data; // [R3] [R4]
            nxt_stall    = 1'b1; // [R3]
            nxt_req      = '{1'b1, NRAC_OP_NONE, ptr_region, ptr_addr, 14'h0000};
        end

        // Register-interface read: the array answers in the same cycle
        if (read_set && op_ff == OP_IDLE) begin
            nxt_read  = 1'b0; // [R7]
            nxt_stall = 1'b1; // [R7]
            if (!code_protect && readable(ctrl_ff.config_space_select, addr_ff)) begin
                nxt_word = array_rd_data; // [R7] [R5]
                nxt_req  = '{1'b1, NRAC_OP_NONE, ctrl_ff.config_space_select,
                             addr_ff, 14'h0000};
            end else begin
                nxt_word = 14'h0000;
            end
        end

        case (op_ff)
            OP_IDLE: begin
                if (unlocked_go) begin
                    if (!req_ok || (write_protect && req_kind != NRAC_OP_LATCH
                                    && req_kind != NRAC_OP_EE_WRITE)) begin
                        nxt_start = 1'b0; // [R17]
                        nxt_err   = 1'b1;
                    end else if (req_kind == NRAC_OP_LATCH) begin
                        latch_we  = 1'b1; // [R20] [R19]
                        nxt_stall = 1'b1; // [R12]
                    end else begin
                        nxt_start = 1'b1;
                        nxt_kind  = req_kind;
                        nxt_op    = OP_RUN;
                        nxt_cnt   = (req_kind == NRAC_OP_EE_WRITE) ? `NRAC_EE_WRITE_CYC
                                  : (req_kind == NRAC_OP_ERASE) ? `NRAC_ERASE_CYC
                                  : `NRAC_PROG_CYC;
                        nxt_stall = (req_kind != NRAC_OP_EE_WRITE); // [R12] [R18]
                    end
                end
            end
            OP_RUN: begin
                nxt_stall = (kind_ff != NRAC_OP_EE_WRITE); // [R14] [R18]
                // Program streams word 31 down to 0; the latch read is registered,
                // so its index runs one beat ahead. No erase is issued.
                latch_rd_idx = cnt_ff[4:0] - 5'h02;
                // Beats stop at zero so a slow array is not re-armed while it drains
                if (cnt_ff != 16'h0000) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                    nxt_req = '{1'b1, kind_ff, ctrl_ff.config_space_select,
                                kind_ff == NRAC_OP_PROG
                                    ? {addr_ff[15:5], cnt_ff[4:0] - 5'h01}
                                    : (kind_ff == NRAC_OP_ERASE
                                        ? {addr_ff[15:5], 5'h00} : addr_ff),
                                kind_ff == NRAC_OP_PROG ? latch_rd
                                    : (kind_ff == NRAC_OP_ERASE ? `NRAC_LATCH_BLANK
                                        : {6'h00, word_value_ff[7:0]})}; // [R1] [R19] [R22]
                end else if (!array_busy) begin
                    nxt_op = OP_FINISH;
                end
            end
            OP_FINISH: begin
                nxt_start = 1'b0; // [R14]
                nxt_done  = 1'b1; // [R14] [R18]
                nxt_op    = OP_IDLE;
                if (kind_ff == NRAC_OP_PROG || kind_ff == NRAC_OP_ERASE)
                    latch_blank = 1'b1; // [R21]
            end
            default: nxt_op = OP_IDLE;
        endcase

        // A software clear only lands when nothing is running
        if (start_clr && op_ff == OP_IDLE && !unlocked_go)
            nxt_start = 1'b0; // [R15]
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            op_ff                  <= OP_IDLE;
            kind_ff                <= NRAC_OP_NONE;
            cnt_ff                 <= 16'h0000;
            ctrl_ff                <= '0;
            addr_ff                <= 16'h0000;
            word_value_ff          <= 14'h0000;
            ptr_data_ff            <= 14'h0000;
            start_ff               <= 1'b0;
            read_ff                <= 1'b0;
            operation_done_flag_ff <= 1'b0;
            done_irq_ff            <= 1'b0;
            write_error_ff         <= 1'b0;
            cpu_stall_ff           <= 1'b0;
            array_req_ff           <= '0;
        end else begin
            op_ff                  <= nxt_op;
            kind_ff                <= nxt_kind;
            cnt_ff                 <= nxt_cnt;
            ctrl_ff                <= nxt_ctrl;
            addr_ff                <= nxt_addr;
            word_value_ff          <= nxt_word;
            ptr_data_ff            <= nxt_ptr_data;
            start_ff               <= nxt_start;
            read_ff                <= nxt_read;
            operation_done_flag_ff <= nxt_done;
            done_irq_ff            <= nxt_done && nxt_ctrl.done_interrupt_enable; // [R14]
            write_error_ff         <= nxt_err;
            cpu_stall_ff           <= nxt_stall;
            array_req_ff           <= nxt_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Keys may come back to back or with one idle cycle between them
    sequence s_unlock;
        key_wr && key_data == `NRAC_KEY_FIRST && unl_ff == UNL_IDLE
        ##[1:2] key_wr && key_data == `NRAC_KEY_SECOND && unl_ff == UNL_KEY1;
    endsequence

    a_unlock_order: assert property (@(posedge clock) disable iff (srst) // [R8]
        unlocked_go |-> $past(unl_ff) inside {UNL_KEY1, UNL_KEY2} && unl_ff == UNL_KEY2)
        else $error("start accepted without both keys");
    a_unlock_reach: assert property (@(posedge clock) disable iff (srst) // [R8]
        s_unlock |=> unl_ff == UNL_KEY2)
        else $error("key pair did not arm the unlock");
    a_unlock_abandon: assert property (@(posedge clock) disable iff (srst) // [R24]
        (unl_ff == UNL_KEY1 && !key_wr && (ctrl_wr || data_wr)) |=> unl_ff == UNL_IDLE)
        else $error("broken sequence kept its state");
    a_no_latch_locked: assert property (@(posedge clock) disable iff (srst) // [R10]
        latch_we |-> unlocked_go)
        else $error("latch loaded without unlock");
    a_read_stall: assert property (@(posedge clock) disable iff (srst) // [R7]
        (read_set && op_ff == OP_IDLE) |=> cpu_stall_ff && !read_ff)
        else $error("read did not stall one cycle");
    a_ptr_one_cycle: assert property (@(posedge clock) disable iff (srst) // [R3]
        (ptr_rd && !ptr_wr && !read_set && !unlocked_go && op_ff == OP_IDLE)
        |=> cpu_stall_ff ##1 !cpu_stall_ff || $past(ptr_rd, 1) || $past(read_set, 1))
        else $error("pointer read stall not one cycle");
    a_cp_blocks: assert property (@(posedge clock) disable iff (srst) // [R5]
        (code_protect && unlocked_go) |=> op_ff == OP_IDLE && write_error_ff)
        else $error("operation started under code protection");
    a_ee_no_stall: assert property (@(posedge clock) disable iff (srst) // [R14]
        (op_ff == OP_RUN && kind_ff == NRAC_OP_EE_WRITE) |=> !cpu_stall_ff)
        else $error("EEPROM write stalled the CPU");
    a_start_holds: assert property (@(posedge clock) disable iff (srst) // [R15]
        (op_ff == OP_RUN && start_clr) |=> start_ff)
        else $error("start cleared while running");
    a_done_after: assert property (@(posedge clock) disable iff (srst) // [R14] [R18]
        op_ff == OP_FINISH |=> operation_done_flag_ff && !start_ff)
        else $error("completion did not set done");

endmodule

`default_nettype wire

/* File: nrac_array_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Storage arrays behind the controller; flash bits only ever program toward 0
module nrac_array_model
    import nrac_pkg::*;
(
    // Clock and request
    input  wire logic                  clock,
    input  wire nrac_pkg::nrac_array_req_t req,
    input  wire logic                  slow,
    // Read address
    input  wire logic                  rd_region,
    input  wire logic [15:0]           rd_addr,
    // Answers
    output logic      [13:0]           rd_data,
    output logic                       busy
);
    logic [13:0] fl [32768];
    logic [7:0]  ee [256];
    int          cnt = 0;

    initial begin
        for (int i = 0; i < 32768; i++) fl[i] = 14'(i) ^ 14'h2A5A;
        for (int i = 0; i < 256; i++) ee[i] = 8'hFF;
    end

    // Unmapped config space reads back as zero
    assign rd_data = rd_region ? ((rd_addr[15:8] == 8'hF0) ? {6'h00, ee[rd_addr[7:0]]} : 14'h0000)
                               : fl[rd_addr[14:0]];
    assign busy = (cnt > 0);

    always @(posedge clock) begin
        if (req.valid && req.op != NRAC_OP_LATCH) cnt <= slow ? 5 : 0;
        else if (cnt > 0) cnt <= cnt - 1;
        if (req.valid) begin
            case (req.op)
                NRAC_OP_ERASE: for (int i = 0; i < 32; i++) fl[{req.addr[14:5], 5'(i)}] <= 14'h3FFF;
                NRAC_OP_PROG: fl[req.addr[14:0]] <= fl[req.addr[14:0]] & req.data;
                NRAC_OP_EE_WRITE: ee[req.addr[7:0]] <= req.data[7:0];
                default: ;
            endcase
        end
    end
endmodule

`default_nettype wire

/* File: test_nvm_register_access_controller.sv */
`timescale 1ns/1ps
`default_nettype none

module test_nvm_register_access_controller;
    import nrac_pkg::*;
    logic clock = 0, srst = 1, code_protect = 0, write_protect = 0, ptr_region = 0, slow = 0;
    logic [9:0] p = '0;
    logic [15:0] dv = '0, addr_ff;
    logic [13:0] word_value_ff, ptr_data_ff, array_rd_data, v;
    logic start_ff, read_ff, operation_done_flag_ff, done_irq_ff, write_error_ff, cpu_stall_ff;
    logic array_busy;
    nrac_ctrl_t ctrl_ff;
    nrac_array_req_t array_req_ff;
    int n_errors = 0, num_checks = 0, stalls = 0, s0, cyc = 0;

    nrac_ctrl i_dut (.clock(clock), .srst(srst), .key_wr(p[0]), .key_data(dv[7:0]),
        .ctrl_wr(p[1]), .ctrl_data(nrac_ctrl_t'(dv[4:0])), .start_set(p[2]), .start_clr(p[3]),
        .read_set(p[4]), .addr_wr(p[5]), .addr_data(dv), .data_wr(p[6]), .data_data(dv[13:0]),
        .done_clr(p[7]), .ptr_rd(p[8]), .ptr_wr(p[9]), .ptr_region(ptr_region), .ptr_addr(dv),
        .code_protect(code_protect), .write_protect(write_protect),
        .array_rd_data(array_rd_data), .array_busy(array_busy), .ctrl_ff(ctrl_ff),
        .addr_ff(addr_ff), .word_value_ff(word_value_ff), .ptr_data_ff(ptr_data_ff),
        .start_ff(start_ff), .read_ff(read_ff), .operation_done_flag_ff(operation_done_flag_ff),
        .done_irq_ff(done_irq_ff), .write_error_ff(write_error_ff), .cpu_stall_ff(cpu_stall_ff),
        .array_req_ff(array_req_ff));
    nrac_array_model i_arr (.clock(clock), .req(array_req_ff), .slow(slow),
        .rd_region(p[8] ? ptr_region : ctrl_ff.config_space_select),
        .rd_addr(p[8] ? dv : addr_ff), .rd_data(array_rd_data), .busy(array_busy));

    initial forever #10 clock = ~clock;
    always @(negedge clock) stalls += int'(cpu_stall_ff === 1'b1);
    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [13:0] pat(input logic [15:0] a);
        return a[13:0] ^ 14'h2A5A;
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One software pulse on line b, with its value on the shared data bus
    task automatic pulse(input int b, input logic [15:0] val);
        @(posedge clock);
        p <= 10'(1) << b;
        dv <= val;
        @(posedge clock);
        p <= '0;
    endtask
    task automatic rst;
        srst <= 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
    endtask
    // Keys and start; brk slips a data write in between the keys
    task automatic unlock(input bit brk);
        s0 = stalls;
        pulse(0, 16'h0055);
        if (brk) pulse(6, 16'h0AAA);
        pulse(0, 16'h00AA);
        pulse(2, 16'h0000);
        @(posedge clock);
        #1;
    endtask
    task automatic rdw(input logic rg, input logic [15:0] a);
        pulse(1, {11'h000, rg, 4'h0});
        pulse(5, a);
        s0 = stalls;
        pulse(4, 16'h0000);
        @(posedge clock);
        #1;
        v = word_value_ff;
    endtask
    task automatic wdone;
        for (int i = 0; i < 400 && operation_done_flag_ff !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("done", operation_done_flag_ff, 1);
        chk("start", start_ff, 0);
    endtask
    task automatic setop(input logic [4:0] c, input logic [15:0] a, input logic [15:0] d);
        pulse(1, c);
        pulse(5, a);
        pulse(6, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_read;
        rdw(0, 16'h0123);
        chk("word", v, pat(16'h0123));
        chk("read", read_ff, 0);
        chk("stall", stalls - s0, 1);
        code_protect <= 1'b1;
        rdw(0, 16'h0124);
        chk("cp word", v, 14'h0000);
        code_protect <= 1'b0;
        ptr_region <= 1'b0;
        s0 = stalls;
        pulse(8, 16'h0077);
        @(posedge clock);
        #1;
        chk("ptr", ptr_data_ff, pat(16'h0077));
        chk("ptr stall", stalls - s0, 1);
        pulse(9, 16'h0078);
        #1;
        chk("ptr wr", {array_req_ff.valid, start_ff}, 0);
        $display("t_read done");
    endtask
    task automatic t_erase(input bit wp);
        setop(5'b01010, 16'h0045, 16'h0000);
        write_protect <= wp;
        slow <= 1'b1;
        unlock(0);
        if (wp) begin
            repeat (3) @(posedge clock);
            #1;
            chk("wp start", start_ff, 0);
            chk("wp err", write_error_ff, 1);
            rdw(0, 16'h0045);
            chk("wp word", v, pat(16'h0045));
        end else begin
            chk("er start", start_ff, 1);
            wdone();
            chk("er stall", 16'(stalls - s0 >= 64), 1);
            chk("permit", ctrl_ff.program_permit, 1);
            pulse(7, 16'h0000);
            for (int a = 16'h003F; a <= 16'h0060; a++) begin
                rdw(0, 16'(a));
                chk("erased", v, (a inside {16'h003F, 16'h0060}) ? pat(16'(a)) : 14'h3FFF);
            end
        end
        write_protect <= 1'b0;
        slow <= 1'b0;
        $display("t_erase done");
    endtask
    task automatic t_prog;
        for (int i = 0; i < 3; i++) begin
            setop(5'b01100, 16'(16'h0040 + i), 16'(16'h1230 + i));
            unlock(i == 2);
            chk("ld stall", stalls - s0, (i == 2) ? 0 : 1);
        end
        setop(5'b01000, 16'h0040, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) pulse(5, 16'h0060);
            unlock(0);
            wdone();
            chk("pg stall", 16'(stalls - s0 >= 32), 1);
            pulse(7, 16'h0000);
        end
        for (int i = 0; i < 3; i++) begin
            rdw(0, 16'(16'h0040 + i));
            chk("prog", v, (i == 2) ? 14'h3FFF : 14'(16'h1230 + i));
        end
        rdw(0, 16'h0060);
        chk("blank", v, pat(16'h0060));
        $display("t_prog done");
    endtask
    task automatic t_ee;
        setop(5'b11001, 16'hF010, 16'h03C5);
        code_protect <= 1'b1;
        unlock(0);
        chk("cp start", start_ff, 0);
        code_protect <= 1'b0;
        unlock(0);
        chk("ee start", start_ff, 1);
        pulse(3, 16'h0000);
        chk("ee clr", start_ff, 1);
        wdone();
        chk("irq", done_irq_ff, 1);
        chk("ee stall", stalls - s0, 0);
        chk("permit", ctrl_ff.program_permit, 1);
        pulse(7, 16'h0000);
        rdw(1, 16'hF010);
        chk("ee word", v, 14'h00C5);
        rdw(1, 16'hF011);
        chk("ee next", v, 14'h00FF);
        $display("t_ee done");
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        rst();
        t_read();
        t_erase(1);
        rst();
        chk("err rst", write_error_ff, 0);
        t_erase(0);
        t_prog();
        t_ee();
        end_sim();
    end
endmodule

`default_nettype wire
